// ---- core/rsc_defines.vh ----
// Constants for the reset state controller: register map, field positions,
// reset values, cause codes and slow-clock timing.
// Assumes inclusion by bare name from core/ sources; definitions only.
//
// Behaviour
// - Watchdog reset state lasts three slow cycles
// - Watchdog, full: cpu, peripherals, pin pulse
// - Own pin pulse never becomes user reset
// - Watchdog, cpu only: only processor reset
// - Watchdog reset disabled: fault ignored entirely
// - Priority: general, backup, watchdog, user, software
// - Watchdog fault preempts running software reset
// - Pin ignored during software reset
// - Watchdog state blocks user and software resets
// - Status bit 16 shows sampled pin level
// - Pin falling edge sets sticky seen bit
// - Interrupt: seen, user reset off, irq on
// - Status bit 17 busy during software reset
// - Writes need key byte 0xa5, else dropped
// - Command bits: cpu, peripherals, pin on one
// - Cause field bits 10:8, not cleared on read
// - User reset enable gates pin-low reset
// - Pin pulse lasts two to the power length-plus-one slow cycles
// - Software reset three slow cycles, immediate assert
// - Command writes ignored while software reset busy
// - Cause updated at processor reset release only
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

`define RSC_ADDR_W        4
`define RSC_OFF_CMD       4'h0
`define RSC_OFF_STATUS    4'h4
`define RSC_OFF_MODE      4'h8

`define RSC_KEY_MSB       31
`define RSC_KEY_LSB       24
`define RSC_KEY_VALUE     8'ha5

`define RSC_CMD_CPU       0
`define RSC_CMD_PERIPH    2
`define RSC_CMD_PIN       3

`define RSC_ST_SEEN       0
`define RSC_ST_CAUSE_LSB  8
`define RSC_ST_CAUSE_MSB  10
`define RSC_ST_PIN_LVL    16
`define RSC_ST_BUSY       17

`define RSC_MD_UEN        0
`define RSC_MD_IEN        4
`define RSC_MD_LEN_LSB    8
`define RSC_MD_LEN_MSB    11
`define RSC_MD_UEN_RST    1'b1
`define RSC_MD_IEN_RST    1'b0
`define RSC_MD_LEN_RST    4'h0

`define RSC_CAUSE_GENERAL 3'h0
`define RSC_CAUSE_BACKUP  3'h1
`define RSC_CAUSE_WDOG    3'h2
`define RSC_CAUSE_SOFT    3'h3
`define RSC_CAUSE_USER    3'h4

`define RSC_RESP_OKAY     2'h0
`define RSC_RESP_SLVERR   2'h2

`define RSC_CLK_HZ        100000000
`define RSC_SLOW_HZ       32768
`define RSC_HOLD_LAST     2'h2
`define RSC_GUARD_LOAD    2'h3

`endif

// ---- core/rsc_pulse_timer.v ----
// Pin pulse timer: counts 2^(len+1) slow ticks after a start pulse.
// Assumes tick is a one-cycle enable on the same clock as aclk.
`timescale 1ns/1ps
module rsc_pulse_timer #(
  parameter LEN_W = 4,
  parameter CNT_W = 17
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             tick,
  input  wire             start,
  input  wire [LEN_W-1:0] len,
  output wire             active
);
  reg  [CNT_W-1:0] cnt_ff;
  reg  [CNT_W-1:0] nxt_cnt;
  wire [CNT_W-1:0] one = {{(CNT_W-1){1'b0}}, 1'b1};

  assign active = |cnt_ff;

  always @*
  begin
    nxt_cnt = cnt_ff;
    if (start)
      // One extra bit keeps the largest length from wrapping the shift to zero.
      nxt_cnt = one << ({1'b0, len} + {{LEN_W{1'b0}}, 1'b1});
    else if (tick && active)
      nxt_cnt = cnt_ff - one;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      cnt_ff <= {CNT_W{1'b0}};
    else
      cnt_ff <= nxt_cnt;
  end
endmodule

// ---- core/rsc_reset_ctrl.v ----
// Reset state controller with an AXI4-Lite register port.
// Assumes one 100 MHz clock; the slow clock is a divided enable pulse.
// Supply requests and the reset pin are asynchronous and synchronised here.
`timescale 1ns/1ps
`include "rsc_defines.vh"
module rsc_reset_ctrl #(
  parameter SLOW_DIV = `RSC_CLK_HZ / `RSC_SLOW_HZ
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        general_reset_req,
  input  wire        backup_reset_req,
  input  wire        watchdog_fault,
  input  wire        watchdog_reset_enable,
  input  wire        watchdog_proc_only,
  input  wire        pin_in,
  output wire        pin_out,
  output wire        pin_oe,
  output wire        cpu_reset_n,
  output wire        periph_reset_n,
  output wire        reset_irq
);
  localparam ST_GEN  = 3'h0;
  localparam ST_BKP  = 3'h1;
  localparam ST_WDT  = 3'h2;
  localparam ST_SOFT = 3'h3;
  localparam ST_USER = 3'h4;
  localparam ST_IDLE = 3'h5;
  localparam DIV_W   = 16;
  localparam [DIV_W-1:0] DIV_LAST = SLOW_DIV[DIV_W-1:0] - 16'h0001;

  // Slow clock enable.
  reg  [DIV_W-1:0] div_ff;
  reg              tick_ff;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_ff  <= {DIV_W{1'b0}};
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (div_ff == DIV_LAST);
      div_ff  <= (div_ff == DIV_LAST) ? {DIV_W{1'b0}} : div_ff + 16'h0001;
    end
  end

  // Asynchronous inputs pass two flops first.
  reg pin_s1_ff, pin_s2_ff, pin_lvl_ff;
  reg gen_s1_ff, gen_s2_ff, bkp_s1_ff, bkp_s2_ff;
  reg pin_sl1_ff, pin_sl2_ff;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // The pin is pulled low during reset, so no false edge follows release.
      pin_s1_ff  <= 1'b0;
      pin_s2_ff  <= 1'b0;
      pin_lvl_ff <= 1'b0;
      gen_s1_ff  <= 1'b0;
      gen_s2_ff  <= 1'b0;
      bkp_s1_ff  <= 1'b0;
      bkp_s2_ff  <= 1'b0;
      pin_sl1_ff <= 1'b1;
      pin_sl2_ff <= 1'b1;
    end
    else
    begin
      pin_s1_ff  <= pin_in;
      pin_s2_ff  <= pin_s1_ff;
      pin_lvl_ff <= pin_s2_ff;
      gen_s1_ff  <= general_reset_req;
      gen_s2_ff  <= gen_s1_ff;
      bkp_s1_ff  <= backup_reset_req;
      bkp_s2_ff  <= bkp_s1_ff;
      if (tick_ff)
      begin
        pin_sl1_ff <= pin_s2_ff;
        pin_sl2_ff <= pin_sl1_ff;
      end
    end
  end

  // AXI4-Lite slave: one write and one read outstanding.
  reg        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg        aw_full_ff, w_full_ff;
  reg [3:0]  awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0]  wstrb_ff;
  reg [1:0]  bresp_ff, rresp_ff;
  reg [31:0] rdata_ff;

  wire aw_hs   = s_axi_awvalid & awready_ff;
  wire w_hs    = s_axi_wvalid & wready_ff;
  wire ar_hs   = s_axi_arvalid & arready_ff;
  wire wr_fire = aw_full_ff & w_full_ff & ~bvalid_ff;
  wire wr_map  = (awaddr_ff == `RSC_OFF_CMD) | (awaddr_ff == `RSC_OFF_MODE);
  wire key_ok  = wstrb_ff[3] & (wdata_ff[`RSC_KEY_MSB:`RSC_KEY_LSB] == `RSC_KEY_VALUE);
  wire cmd_wr  = wr_fire & key_ok & (awaddr_ff == `RSC_OFF_CMD) & wstrb_ff[0];
  wire mode_wr = wr_fire & key_ok & (awaddr_ff == `RSC_OFF_MODE);
  wire st_rd   = ar_hs & (s_axi_araddr == `RSC_OFF_STATUS);

  // Mode register.
  reg       uen_ff, ien_ff;
  reg [3:0] len_ff;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      uen_ff <= `RSC_MD_UEN_RST;
      ien_ff <= `RSC_MD_IEN_RST;
      len_ff <= `RSC_MD_LEN_RST;
    end
    else if (mode_wr)
    begin
      if (wstrb_ff[0])
      begin
        uen_ff <= wdata_ff[`RSC_MD_UEN];
        ien_ff <= wdata_ff[`RSC_MD_IEN];
      end
      if (wstrb_ff[1])
        len_ff <= wdata_ff[`RSC_MD_LEN_MSB:`RSC_MD_LEN_LSB];
    end
  end

  // Reset state machine.
  reg  [2:0] state_ff, nxt_state;
  reg  [1:0] cnt_ff, nxt_cnt;
  reg  [1:0] guard_ff;
  reg        soft_cpu_ff, nxt_soft_cpu;
  reg        soft_per_ff, nxt_soft_per;
  reg        wdt_po_ff, nxt_wdt_po;
  reg        wdt_pend_ff;
  reg        pin_start;
  reg        wdt_take;
  reg  [2:0] cause_ff;
  reg        seen_ff, nxt_seen;
  reg        cpu_n_ff, per_n_ff, oe_ff, irq_ff;
  reg        nxt_cpu_n, nxt_per_n;
  wire       timer_active;
  wire       busy     = (state_ff == ST_SOFT);
  reg        soft_pin_ff, nxt_soft_pin;
  wire       wd_cpu   = wdata_ff[`RSC_CMD_CPU];
  wire       wd_per   = wdata_ff[`RSC_CMD_PERIPH];
  wire       wd_pin   = wdata_ff[`RSC_CMD_PIN];
  wire       user_req = ~pin_sl2_ff & ~timer_active & (guard_ff == 2'h0);

  wire       wdt_set  = watchdog_fault & watchdog_reset_enable &
                        (state_ff != ST_WDT) & (state_ff != ST_USER);
  always @(posedge aclk)
  begin
    if (!aresetn)
      wdt_pend_ff <= 1'b0;
    else
      wdt_pend_ff <= wdt_set | (wdt_pend_ff & ~wdt_take);
  end

  always @*
  begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_soft_cpu = soft_cpu_ff;
    nxt_soft_per = soft_per_ff;
    nxt_wdt_po   = wdt_po_ff;
    nxt_soft_pin = soft_pin_ff & ~tick_ff;
    pin_start    = 1'b0;
    wdt_take     = 1'b0;
    if (tick_ff)
    begin
      if (gen_s2_ff)
        nxt_state = ST_GEN;
      else if (bkp_s2_ff)
      begin
        // The count stays at zero while held, so release takes three ticks.
        nxt_state = ST_BKP;
        nxt_cnt   = 2'h0;
      end
      else if (wdt_pend_ff && state_ff != ST_GEN && state_ff != ST_BKP)
      begin
        wdt_take     = 1'b1;
        nxt_state    = ST_WDT;
        nxt_cnt      = 2'h0;
        nxt_wdt_po   = watchdog_proc_only;
        nxt_soft_cpu = 1'b0;
        nxt_soft_per = 1'b0;
        pin_start    = ~watchdog_proc_only;
      end
      else
      begin
        case (state_ff)
          ST_GEN:
          begin
            nxt_state = ST_IDLE;
            pin_start = 1'b1;
          end
          ST_BKP:
          begin
            if (cnt_ff == `RSC_HOLD_LAST)
              nxt_state = ST_IDLE;
            else
              nxt_cnt = cnt_ff + 2'h1;
          end
          ST_WDT:
          begin
            if (cnt_ff == `RSC_HOLD_LAST)
              nxt_state = ST_IDLE;
            else
              nxt_cnt = cnt_ff + 2'h1;
          end
          ST_SOFT:
          begin
            if (cnt_ff == `RSC_HOLD_LAST)
            begin
              nxt_state    = ST_IDLE;
              nxt_soft_cpu = 1'b0;
              nxt_soft_per = 1'b0;
            end
            else
              nxt_cnt = cnt_ff + 2'h1;
          end
          ST_USER:
          begin
            if (!pin_sl2_ff)
              nxt_cnt = 2'h0;
            else if (cnt_ff == `RSC_HOLD_LAST)
              nxt_state = ST_IDLE;
            else
              nxt_cnt = cnt_ff + 2'h1;
          end
          ST_IDLE:
          begin
            if (uen_ff && user_req)
            begin
              nxt_state = ST_USER;
              nxt_cnt   = 2'h0;
            end
          end
          default:
            nxt_state = ST_IDLE;
        endcase
      end
    end
    // A software pin pulse starts on a slow tick so it lasts whole slow cycles.
    if (tick_ff && soft_pin_ff)
      pin_start = 1'b1;
    if (cmd_wr && state_ff == ST_IDLE && nxt_state == ST_IDLE && (wd_cpu | wd_per | wd_pin))
    begin
      nxt_state    = ST_SOFT;
      nxt_cnt      = 2'h0;
      nxt_soft_cpu = wd_cpu;
      nxt_soft_per = wd_per;
      nxt_soft_pin = wd_pin;
    end
  end

  always @*
  begin
    nxt_cpu_n = 1'b1;
    nxt_per_n = 1'b1;
    case (nxt_state)
      ST_GEN, ST_BKP, ST_USER:
      begin
        nxt_cpu_n = 1'b0;
        nxt_per_n = 1'b0;
      end
      ST_WDT:
      begin
        nxt_cpu_n = 1'b0;
        nxt_per_n = nxt_wdt_po;
      end
      ST_SOFT:
      begin
        nxt_cpu_n = ~nxt_soft_cpu;
        nxt_per_n = ~nxt_soft_per;
      end
      default:
      begin
        nxt_cpu_n = 1'b1;
        nxt_per_n = 1'b1;
      end
    endcase
  end

  always @*
  begin
    nxt_seen = (seen_ff & ~st_rd) | (pin_lvl_ff & ~pin_s2_ff);
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff    <= ST_GEN;
      cnt_ff      <= 2'h0;
      soft_cpu_ff <= 1'b0;
      soft_per_ff <= 1'b0;
      wdt_po_ff   <= 1'b0;
      soft_pin_ff <= 1'b0;
      cause_ff    <= `RSC_CAUSE_GENERAL;
      seen_ff     <= 1'b0;
      cpu_n_ff    <= 1'b0;
      per_n_ff    <= 1'b0;
      oe_ff       <= 1'b1;
      irq_ff      <= 1'b0;
      guard_ff    <= `RSC_GUARD_LOAD;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      soft_cpu_ff <= nxt_soft_cpu;
      soft_per_ff <= nxt_soft_per;
      wdt_po_ff   <= nxt_wdt_po;
      soft_pin_ff <= nxt_soft_pin;
      cpu_n_ff    <= nxt_cpu_n;
      per_n_ff    <= nxt_per_n;
      seen_ff     <= nxt_seen;
      oe_ff       <= timer_active | (state_ff == ST_GEN);
      irq_ff      <= nxt_seen & ~uen_ff & ien_ff;
      // The guard spans the two-stage slow resync after our own pulse ends.
      if (timer_active || state_ff == ST_GEN)
        guard_ff <= `RSC_GUARD_LOAD;
      else if (tick_ff && guard_ff != 2'h0)
        guard_ff <= guard_ff - 2'h1;
      if (nxt_cpu_n && !cpu_n_ff)
        cause_ff <= state_ff;
    end
  end

  rsc_pulse_timer #(
    .LEN_W (4),
    .CNT_W (17)
  ) u_pin_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick_ff),
    .start   (pin_start),
    .len     (len_ff),
    .active  (timer_active)
  );

  // Bus channel handling.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RSC_RESP_OKAY;
      awaddr_ff  <= 4'h0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `RSC_RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      if (aw_hs)
      begin
        awaddr_ff  <= s_axi_awaddr;
        aw_full_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (w_hs)
      begin
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        w_full_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_map ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
        aw_full_ff <= 1'b0;
        w_full_ff  <= 1'b0;
      end
      if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
      if (ar_hs)
      begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rresp_ff   <= `RSC_RESP_OKAY;
        rdata_ff   <= 32'h0000_0000;
        case (s_axi_araddr)
          `RSC_OFF_CMD:
            rdata_ff <= 32'h0000_0000;
          `RSC_OFF_STATUS:
          begin
            rdata_ff[`RSC_ST_SEEN]                       <= seen_ff;
            rdata_ff[`RSC_ST_CAUSE_MSB:`RSC_ST_CAUSE_LSB] <= cause_ff;
            rdata_ff[`RSC_ST_PIN_LVL]                    <= pin_lvl_ff;
            rdata_ff[`RSC_ST_BUSY]                       <= busy;
          end
          `RSC_OFF_MODE:
          begin
            rdata_ff[`RSC_MD_UEN]                     <= uen_ff;
            rdata_ff[`RSC_MD_IEN]                     <= ien_ff;
            rdata_ff[`RSC_MD_LEN_MSB:`RSC_MD_LEN_LSB] <= len_ff;
          end
          default:
            rresp_ff <= `RSC_RESP_SLVERR;
        endcase
      end
      if (rvalid_ff && s_axi_rready)
      begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  reg pin_out_ff;
  always @(posedge aclk)
  begin
    pin_out_ff <= 1'b0;
  end

  assign s_axi_awready  = awready_ff;
  assign s_axi_wready   = wready_ff;
  assign s_axi_bvalid   = bvalid_ff;
  assign s_axi_bresp    = bresp_ff;
  assign s_axi_arready  = arready_ff;
  assign s_axi_rvalid   = rvalid_ff;
  assign s_axi_rresp    = rresp_ff;
  assign s_axi_rdata    = rdata_ff;
  assign pin_out        = pin_out_ff;
  assign pin_oe         = oe_ff;
  assign cpu_reset_n    = cpu_n_ff;
  assign periph_reset_n = per_n_ff;
  assign reset_irq      = irq_ff;
endmodule

// ---- dv/rsc_reset_ctrl_assertions.sv ----
// Port checker for the reset state controller.
// Assumes a bind onto rsc_reset_ctrl with its slow divider handed on.
`timescale 1ns/1ps
module rsc_checker #(
  parameter int SLOW_DIV = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        watchdog_fault,
  input wire logic        watchdog_reset_enable,
  input wire logic        watchdog_proc_only,
  input wire logic        pin_in,
  input wire logic        pin_out,
  input wire logic        pin_oe,
  input wire logic        cpu_reset_n,
  input wire logic        periph_reset_n,
  input wire logic        reset_irq
);
  // A fault waits for the next slow tick, then the outputs follow a clock or two later.
  localparam int WD_MAX = SLOW_DIV + 4;
  localparam int OE_MAX = SLOW_DIV + 6;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire wd_hit = watchdog_fault && watchdog_reset_enable && cpu_reset_n;
  wire ar_hs  = s_axi_arvalid && s_axi_arready;
  property p_pin_low; pin_out == 1'b0; endproperty
  property p_wd_enter; wd_hit |-> ##[1:WD_MAX] !cpu_reset_n; endproperty
  property p_wd_full;
    wd_hit && !watchdog_proc_only |-> ##[1:OE_MAX] (!periph_reset_n && pin_oe);
  endproperty
  property p_wd_cpu_only;
    wd_hit && watchdog_proc_only && periph_reset_n && !pin_oe |->
      ##[1:WD_MAX] !cpu_reset_n ##0 periph_reset_n ##1 (periph_reset_n && !pin_oe) [*8];
  endproperty
  property p_own_pulse; $fell(pin_oe) && cpu_reset_n |-> cpu_reset_n [*8]; endproperty
  property p_rd_lat; ar_hs |=> s_axi_rvalid && !s_axi_arready; endproperty
  property p_rd_err;
    ar_hs && s_axi_araddr == 4'hc |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_irq_clr;
    pin_in [*5] ##0 (ar_hs && s_axi_araddr == 4'h4) |-> ##[1:3] !reset_irq;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin driven high");
  a_wd_enter: assert property (p_wd_enter) else $error("no watchdog reset");
  a_wd_full: assert property (p_wd_full) else $error("watchdog reset not full");
  a_wd_cpu_only: assert property (p_wd_cpu_only) else $error("cpu only reset wide");
  a_own_pulse: assert property (p_own_pulse) else $error("own pulse reset cpu");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_rd_err: assert property (p_rd_err) else $error("unmapped read accepted");
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  a_irq_clr: assert property (p_irq_clr) else $error("irq kept after read");
  c_wd_cpu: cover property (wd_hit && watchdog_proc_only);
  c_irq: cover property ($rose(reset_irq));
  c_pulse: cover property ($fell(pin_oe) && cpu_reset_n);
endmodule
bind rsc_reset_ctrl rsc_checker #(.SLOW_DIV(SLOW_DIV)) u_chk (.*);

// ---- dv/rsc_pin_model.sv ----
// Reset pin wire with a pull-up, a push button and the controller's pull-down.
// Assumes pin_oe high means the controller pulls the line low.
`timescale 1ns/1ps
module rsc_pin_model (
  input  wire pin_oe,
  input  wire pin_out,
  input  wire btn_low,
  output wire pin_in
);
  assign pin_in = ((pin_oe && !pin_out) || btn_low) ? 1'b0 : 1'b1;
endmodule

// ---- dv/rsc_reset_ctrl_test.sv ----
// Self-checking bench for the reset state controller.
// Assumes the pin model on the reset pin and a short slow divider.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module rsc_reset_ctrl_test;
  localparam DIV = 8;
  reg         aclk = 1'b0, aresetn = 1'b0, btn_low = 1'b0;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  reg  [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  reg  [31:0] s_axi_wdata = 32'h0, rd_d;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0;
  reg         general_reset_req = 0, backup_reset_req = 0, watchdog_fault = 0;
  reg         watchdog_reset_enable = 1, watchdog_proc_only = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        pin_in, pin_out, pin_oe, cpu_reset_n, periph_reset_n, reset_irq;
  integer     fail_count = 0, n_checks = 0, seed = 32'hd9bf;
  integer     m_mode = 1, m_cause = 0, cpu_lo, per_lo, oe_cnt, i, k, n;
  rsc_reset_ctrl #(.SLOW_DIV(DIV)) u_dut (.*);
  rsc_pin_model u_pin (.pin_oe(pin_oe), .pin_out(pin_out), .btn_low(btn_low), .pin_in(pin_in));
  always #5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cpu_lo += !cpu_reset_n;
    per_lo += !periph_reset_n;
    oe_cnt += pin_oe;
  end
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task tmo;
    begin
      fail_count++;
      give_verdict;
    end
  endtask
  task clr;
    begin
      cpu_lo = 0;
      per_lo = 0;
      oe_cnt = 0;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d, input [1:0] er);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50 && !(i > 0 && s_axi_bvalid); i++)
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      if (!s_axi_bvalid) tmo;
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
      @(posedge aclk);
    end
  endtask
  task rd(input [3:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50 && !(i > 0 && s_axi_rvalid); i++)
      begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (!s_axi_rvalid) tmo;
      s_axi_rready <= 1'b0;
      rd_d = s_axi_rdata;
      `CHK("rresp", (a == 4'hc) ? 2'h2 : 2'h0, s_axi_rresp)
      @(posedge aclk);
    end
  endtask
  task st(input seen);
    begin
      rd(4'h4);
      `CHK("cause", m_cause[2:0], rd_d[10:8])
      `CHK("seen", seen, rd_d[0])
      `CHK("level", ~btn_low, rd_d[16])
      `CHK("busy", 1'b0, rd_d[17])
    end
  endtask
  task idle;
    begin
      repeat (2) @(posedge aclk);
      for (i = 0; i < 600 && !(cpu_reset_n && periph_reset_n && !pin_oe); i++)
        @(posedge aclk);
      if (i >= 600) tmo;
      // Let any late user reset after our own pulse show up in the counters.
      repeat (4 * DIV) @(posedge aclk);
    end
  endtask
  task wait_lo;
    begin
      for (i = 0; i < 40 && cpu_reset_n; i++)
        @(posedge aclk);
      if (cpu_reset_n) tmo;
    end
  endtask
  task wd_pulse;
    begin
      watchdog_fault <= 1'b1;
      @(posedge aclk);
      watchdog_fault <= 1'b0;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    idle;
    rd(4'h4);
    st(1'b0);
    rd(4'h8);
    `CHK("mode", m_mode, rd_d)
    rd(4'hc);
    wr(4'h4, 32'h0, 2'h2);
    n = $random(seed) & 8'hff;
    if (n == 8'ha5) n = 0;
    wr(4'h8, {n[7:0], 24'h000110}, 2'h0);
    rd(4'h8);
    `CHK("mode", m_mode, rd_d)
    m_mode = 32'h10;
    wr(4'h8, 32'ha5000010, 2'h0);
    rd(4'h8);
    `CHK("mode", m_mode, rd_d)
    clr;
    n = 12 + ($random(seed) & 15);
    btn_low <= 1'b1;
    repeat (n) @(posedge aclk);
    `CHK("irq", 1'b1, reset_irq)
    st(1'b1);
    btn_low <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK("irq", 1'b0, reset_irq)
    `CHK("no_user", 0, cpu_lo)
    st(1'b0);
    m_mode = 32'h101;
    wr(4'h8, 32'ha5000101, 2'h0);
    for (k = 0; k < 3; k++)
    begin
      clr;
      n = (k == 0) ? 0 : k + 1;
      wr(4'h0, 32'ha5000000 | (1 << n), 2'h0);
      rd(4'h4);
      `CHK("busy", 1'b1, rd_d[17])
      if (k > 0) wr(4'h0, 32'ha5000001, 2'h0);
      idle;
      if (k == 0) m_cause = 3;
      `CHK("cpu", k == 0, cpu_lo > 0)
      `CHK("periph", k == 1, per_lo > 0)
      `CHK("pulse", k == 2, oe_cnt >= 4 * DIV && oe_cnt <= 4 * DIV + 2)
      st(k == 2);
    end
    for (k = 0; k < 2; k++)
    begin
      clr;
      watchdog_proc_only <= k;
      wd_pulse;
      wait_lo;
      wr(4'h0, 32'ha5000004, 2'h0);
      idle;
      m_cause = 2;
      `CHK("wd_periph", k == 0, per_lo > 0)
      `CHK("wd_pin", k == 0, oe_cnt > 0)
      st(k == 0);
    end
    clr;
    watchdog_reset_enable <= 1'b0;
    wd_pulse;
    repeat (4 * DIV) @(posedge aclk);
    `CHK("wd_off", 0, cpu_lo + per_lo + oe_cnt)
    watchdog_reset_enable <= 1'b1;
    wr(4'h0, 32'ha5000001, 2'h0);
    wd_pulse;
    idle;
    m_cause = 2;
    st(1'b0);
    m_mode = 32'h1;
    wr(4'h8, 32'ha5000001, 2'h0);
    clr;
    btn_low <= 1'b1;
    wait_lo;
    repeat (4 * DIV) @(posedge aclk);
    btn_low <= 1'b0;
    idle;
    m_cause = 4;
    st(1'b1);
    backup_reset_req <= 1'b1;
    wait_lo;
    backup_reset_req <= 1'b0;
    idle;
    m_cause = 1;
    st(1'b0);
    general_reset_req <= 1'b1;
    backup_reset_req <= 1'b1;
    wait_lo;
    general_reset_req <= 1'b0;
    backup_reset_req <= 1'b0;
    idle;
    rd(4'h4);
    `CHK("cause", 3'h0, rd_d[10:8])
    give_verdict;
  end
endmodule
